//--- shared/comparator_event_control_regs.vh
// register offsets, field positions, reset values and timing counts for the comparator event block
// assumes an AXI4-Lite slave with 32-bit data, one aligned word per register
//
// Contract
// - four independent comparator channels, each with own output, interrupt and configuration
// - negative input: four reference levels, converter output, or external negative pin
// - output bit is one while positive input exceeds selected negative input
// - each comparator is sampled on comparator clock edges, never continuously
// - each channel drives its own dedicated interrupt request, not shared
// - software selects rising, falling or toggle as interrupt trigger per channel
// - each interrupt flag is also a converter trigger event
// - comparator 1 output can be routed to the timer input-capture trigger
// - converter control bit 6 enables the reference-pin current source
// - converter control bit 5 connects internal reference circuit to the pin
// - converter control: bit7 high speed, 6 source, 5 connect, 4 read-only, 3:0 trigger
// - positive pin compared against shared or channel negative pin per selector
// - sense code: 00 toggle, 01 reserved, 10 falling, 11 rising
// - per-channel comparator enable bit and separate per-channel interrupt enable bit
`ifndef COMPARATOR_EVENT_CONTROL_REGS_VH
`define COMPARATOR_EVENT_CONTROL_REGS_VH

`define OFS_CONV_CTRL 8'h00
`define OFS_CH_CTRL0 8'h04
`define OFS_CH_CTRL1 8'h08
`define OFS_CH_CTRL2 8'h0C
`define OFS_CH_CTRL3 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18
`define OFS_CMP_CLK_DIV 8'h1C

`define CONV_CTRL_RESET 8'h00
`define CONV_HS_BIT 7
`define CONV_ISRC_BIT 6
`define CONV_REFPIN_BIT 5
`define CONV_RO_BIT 4

`define CH_ON_BIT 7
`define CH_IE_BIT 6
`define CH_SENSE_HI 5
`define CH_SENSE_LO 4
`define CH_CAPTURE_BIT 3
`define CH_CTRL_RESET 8'h00

`define SENSE_TOGGLE 2'h0
`define SENSE_RESERVED 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3

`define SEL_REF0 3'h0
`define SEL_REF3 3'h3
`define SEL_CONVERTER 3'h5
`define SEL_SHARED_PIN 3'h6
`define SEL_CHANNEL_PIN 3'h7

`define CMP_CLK_DIV_RESET 8'h07

`endif

//--- verilog/comparator_channel.v
// one comparator channel: sampling, edge detection and sticky flag
// assumes the compare result is already on aclk, synchronised by the parent
`timescale 1ns/1ps
`include "comparator_event_control_regs.vh"
module comparator_channel (
    input wire aclk,
    input wire aresetn,
    input wire raw_compare,
    input wire sample_en,
    input wire [7:0] ctrl,
    input wire flag_clear,
    output reg comparator_output,
    output reg flag_r,
    output reg event_r
);
    reg prev_r;
    reg hit;
    wire [1:0] sense = ctrl[`CH_SENSE_HI:`CH_SENSE_LO];
    wire on = ctrl[`CH_ON_BIT];

    // while on, output only moves on a comparator clock tick; cleared at the next clock and held at zero while off
    always @(posedge aclk) begin
        if (!aresetn || !on) begin
            comparator_output <= 1'b0;
            prev_r <= 1'b0;
        end else if (sample_en) begin
            comparator_output <= raw_compare;
            prev_r <= comparator_output;
        end
    end

    // edge selection from the sense field
    always @* begin
        hit = 1'b0;
        case (sense)
            `SENSE_TOGGLE: hit = comparator_output ^ prev_r;
            `SENSE_FALL: hit = prev_r & ~comparator_output;
            `SENSE_RISE: hit = comparator_output & ~prev_r;
            default: hit = 1'b0;
        endcase
    end

    // hit is evaluated once per tick, one cycle after the sample moved
    reg tick_d_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_d_r <= 1'b0;
            flag_r <= 1'b0;
            event_r <= 1'b0;
        end else begin
            tick_d_r <= sample_en & on;
            event_r <= tick_d_r & hit & on;
            // set wins over a clear in the same cycle
            if (tick_d_r && hit && on)
                flag_r <= 1'b1;
            else if (flag_clear)
                flag_r <= 1'b0;
        end
    end
endmodule

//--- verilog/comparator_event_control.v
// comparator bank control with AXI4-Lite register access
// assumes analog compare results for each possible negative input arrive as async levels
`timescale 1ns/1ps
`include "comparator_event_control_regs.vh"
module comparator_event_control (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] cmp_vs_ref,
    input wire [3:0] cmp_vs_converter,
    input wire [3:0] cmp_vs_shared_pin,
    input wire [3:0] cmp_vs_channel_pin,
    output reg [3:0] comparator_output,
    output reg [3:0] channel_irq,
    output reg [3:0] conversion_trigger,
    output reg capture_trigger,
    output reg irq,
    output reg current_source_enable,
    output reg ref_pin_connect,
    output reg converter_high_speed_mode,
    output reg [3:0] conversion_trigger_select,
    output reg [2:0] negative_input_select0,
    output reg [2:0] negative_input_select1,
    output reg [2:0] negative_input_select2,
    output reg [2:0] negative_input_select3
);
    reg [7:0] conv_ctrl_r;
    reg [7:0] ch_ctrl_r [0:3];
    reg [3:0] mask_r;
    reg [7:0] div_r;
    reg [7:0] div_cnt_r;
    reg sample_en_r;
    reg [7:0] aw_addr_r;
    reg aw_held_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_held_r;
    reg [3:0] status_clear;
    wire [3:0] flag;
    wire [3:0] ch_out;
    wire [3:0] ch_evt;
    reg [3:0] raw_sel;
    reg [31:0] ref_s1_r;
    reg [31:0] ref_s2_r;
    reg [11:0] pin_s1_r;
    reg [11:0] pin_s2_r;
    integer i;
    integer m;
    integer k;

    // picks the compare result for the selected negative input
    function pick;
        input [2:0] sel;
        input [7:0] refs;
        input cv;
        input sp;
        input cp;
        begin
            case (sel)
                3'h0, 3'h1, 3'h2, 3'h3: pick = refs[sel[1:0]];
                `SEL_CONVERTER: pick = cv;
                `SEL_SHARED_PIN: pick = sp;
                `SEL_CHANNEL_PIN: pick = cp;
                default: pick = 1'b0;
            endcase
        end
    endfunction

    // merge byte lane 0 of the write data into the register under its strobe
    function [7:0] merge;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge = strb[0] ? data[7:0] : old;
        end
    endfunction

    // every analog level passes two flops before the selector sees it, so a
    // select change can never steer an unsettled level into the edge logic
    always @(posedge aclk) begin
        if (!aresetn) begin
            ref_s1_r <= 32'h0;
            ref_s2_r <= 32'h0;
            pin_s1_r <= 12'h000;
            pin_s2_r <= 12'h000;
        end else begin
            ref_s1_r <= cmp_vs_ref;
            ref_s2_r <= ref_s1_r;
            pin_s1_r <= {cmp_vs_channel_pin, cmp_vs_shared_pin, cmp_vs_converter};
            pin_s2_r <= pin_s1_r;
        end
    end

    // input mux per channel on the synchronised levels
    always @* begin
        for (m = 0; m < 4; m = m + 1) begin
            raw_sel[m] = pick(ch_ctrl_r[m][2:0], {4'h0, ref_s2_r[m*4 +: 4]},
                              pin_s2_r[m], pin_s2_r[4+m], pin_s2_r[8+m]);
        end
    end

    // comparator clock divider: one enable tick every div_r+1 cycles
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_r <= 8'h00;
            sample_en_r <= 1'b0;
        end else if (div_cnt_r >= div_r) begin
            div_cnt_r <= 8'h00;
            sample_en_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
            sample_en_r <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : ch
            comparator_channel u_ch (
                .aclk(aclk),
                .aresetn(aresetn),
                .raw_compare(raw_sel[g]),
                .sample_en(sample_en_r),
                .ctrl(ch_ctrl_r[g]),
                .flag_clear(status_clear[g]),
                .comparator_output(ch_out[g]),
                .flag_r(flag[g]),
                .event_r(ch_evt[g])
            );
        end
    endgenerate

    // write path: address and data taken in either order, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            conv_ctrl_r <= `CONV_CTRL_RESET;
            for (i = 0; i < 4; i = i + 1)
                ch_ctrl_r[i] <= `CH_CTRL_RESET;
            mask_r <= 4'h0;
            div_r <= `CMP_CLK_DIV_RESET;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
            s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (aw_held_r && w_held_r && !s_axi_bvalid) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (aw_addr_r)
                    // bit 4 stays zero, it is read-only
                    `OFS_CONV_CTRL: conv_ctrl_r <= merge(conv_ctrl_r, w_data_r, w_strb_r)
                                                  & 8'hEF;
                    `OFS_CH_CTRL0: ch_ctrl_r[0] <= merge(ch_ctrl_r[0], w_data_r, w_strb_r);
                    `OFS_CH_CTRL1: ch_ctrl_r[1] <= merge(ch_ctrl_r[1], w_data_r, w_strb_r);
                    `OFS_CH_CTRL2: ch_ctrl_r[2] <= merge(ch_ctrl_r[2], w_data_r, w_strb_r);
                    `OFS_CH_CTRL3: ch_ctrl_r[3] <= merge(ch_ctrl_r[3], w_data_r, w_strb_r);
                    `OFS_STATUS: s_axi_bresp <= 2'h0;
                    `OFS_MASK: mask_r <= w_strb_r[0] ? w_data_r[3:0] : mask_r;
                    `OFS_CMP_CLK_DIV: div_r <= merge(div_r, w_data_r, w_strb_r);
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read path: one cycle to arready, data the cycle after; status read clears flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
            status_clear <= 4'h0;
        end else begin
            status_clear <= 4'h0;
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `OFS_CONV_CTRL: s_axi_rdata <= {24'h0, conv_ctrl_r};
                    `OFS_CH_CTRL0: s_axi_rdata <= {24'h0, ch_ctrl_r[0]};
                    `OFS_CH_CTRL1: s_axi_rdata <= {24'h0, ch_ctrl_r[1]};
                    `OFS_CH_CTRL2: s_axi_rdata <= {24'h0, ch_ctrl_r[2]};
                    `OFS_CH_CTRL3: s_axi_rdata <= {24'h0, ch_ctrl_r[3]};
                    `OFS_STATUS: begin
                        s_axi_rdata <= {24'h0, ch_out, flag};
                        status_clear <= flag;
                    end
                    `OFS_MASK: s_axi_rdata <= {28'h0, mask_r};
                    `OFS_CMP_CLK_DIV: s_axi_rdata <= {24'h0, div_r};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // registered outputs toward the rest of the chip
    always @(posedge aclk) begin
        if (!aresetn) begin
            comparator_output <= 4'h0;
            channel_irq <= 4'h0;
            conversion_trigger <= 4'h0;
            capture_trigger <= 1'b0;
            irq <= 1'b0;
            current_source_enable <= 1'b0;
            ref_pin_connect <= 1'b0;
            converter_high_speed_mode <= 1'b0;
            conversion_trigger_select <= 4'h0;
            negative_input_select0 <= 3'h0;
            negative_input_select1 <= 3'h0;
            negative_input_select2 <= 3'h0;
            negative_input_select3 <= 3'h0;
        end else begin
            comparator_output <= ch_out;
            for (k = 0; k < 4; k = k + 1)
                channel_irq[k] <= flag[k] & ch_ctrl_r[k][`CH_IE_BIT];
            conversion_trigger <= ch_evt;
            capture_trigger <= ch_out[1] & ch_ctrl_r[1][`CH_CAPTURE_BIT];
            irq <= |(flag & mask_r);
            current_source_enable <= conv_ctrl_r[`CONV_ISRC_BIT];
            ref_pin_connect <= conv_ctrl_r[`CONV_REFPIN_BIT];
            converter_high_speed_mode <= conv_ctrl_r[`CONV_HS_BIT];
            conversion_trigger_select <= conv_ctrl_r[3:0];
            negative_input_select0 <= ch_ctrl_r[0][2:0];
            negative_input_select1 <= ch_ctrl_r[1][2:0];
            negative_input_select2 <= ch_ctrl_r[2][2:0];
            negative_input_select3 <= ch_ctrl_r[3][2:0];
        end
    end
endmodule

//--- test/analog_side_model.sv
// analog side model: positive input voltages against the possible negative inputs
// assumes small integer voltage codes; levels below are arbitrary plain test values
`timescale 1ns/1ps
module analog_side_model (
    input wire logic [15:0] vpos,
    output logic [31:0] cmp_vs_ref,
    output logic [3:0] cmp_vs_converter,
    output logic [3:0] cmp_vs_shared_pin,
    output logic [3:0] cmp_vs_channel_pin
);
    // reference level k sits at 2+2k, converter 5, shared pin 7, channel pins 9
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            for (int k = 0; k < 4; k++) begin
                cmp_vs_ref[4*n+k] = int'(vpos[4*n+:4]) > 2 + 2 * k;
            end
            cmp_vs_converter[n] = int'(vpos[4*n+:4]) > 5;
            // every channel has its own positive pin, one shared and one own negative pin
            cmp_vs_shared_pin[n] = int'(vpos[4*n+:4]) > 7;
            cmp_vs_channel_pin[n] = int'(vpos[4*n+:4]) > 9;
        end
    end
endmodule

//--- test/comparator_event_control_monitor.sv
// port checker for the comparator event block
// assumes the divider is never set to zero, so sampled outputs move at most every other cycle
`timescale 1ns/1ps
module comparator_event_control_monitor (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] comparator_output,
    input wire [3:0] conversion_trigger,
    input wire capture_trigger,
    input wire current_source_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // responses stand until the master takes them
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_rafter; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rafter: assert property (p_rafter) else $error("read answer late");
    property p_bwin; s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid; endproperty
    a_bwin: assert property (p_bwin) else $error("write answer late");
    // the current source only moves as a result of a register write
    property p_pins; $changed(current_source_enable) |-> $past(s_axi_wready, 1)
        || $past(s_axi_wready, 2) || $past(s_axi_wready, 3); endproperty
    a_pins: assert property (p_pins) else $error("source moved without write");
    // a clocked comparator never changes two cycles running
    property p_sampled; $changed(comparator_output[0]) |=> $stable(comparator_output[0]);
    endproperty
    a_sampled: assert property (p_sampled) else $error("output not sampled");
    property p_trig; conversion_trigger[0] |-> !$stable(comparator_output[0])
        || $past(comparator_output[0], 1) != $past(comparator_output[0], 3); endproperty
    a_trig: assert property (p_trig) else $error("trigger without edge");
    property p_cap; capture_trigger |-> comparator_output[1] || $past(comparator_output[1]);
    endproperty
    a_cap: assert property (p_cap) else $error("capture without output");
endmodule

//--- test/tb_comparator_event_control.sv
// testbench for the comparator event block: register bus master plus analog model
// assumes the hand-over latencies; waits of 24 cycles cover sync, divider and flag stages
`timescale 1ns/1ps
`include "comparator_event_control_regs.vh"
module tb_comparator_event_control;
    logic aclk = 0, aresetn = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 32'h0, rd_data;
    logic awready, wready, bvalid, arready, rvalid, capture_trigger, irq, cse, rpc, hsm;
    logic [1:0] bresp, rresp, rd_resp, wr_resp;
    logic [31:0] rdata, cmp_vs_ref;
    logic [3:0] cvc, cvs, cvp, outs, chirq, convt, tsel;
    logic [15:0] vpos = 16'h0;
    logic [9:0] rows [10];
    wire [2:0] ns0, ns1, ns2, ns3;
    integer errors = 0, n_checks = 0, cyc = 0, n_trig = 0, trig_base = 0;
    comparator_event_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cmp_vs_ref(cmp_vs_ref), .cmp_vs_converter(cvc), .cmp_vs_shared_pin(cvs),
        .cmp_vs_channel_pin(cvp), .comparator_output(outs), .channel_irq(chirq),
        .conversion_trigger(convt), .capture_trigger(capture_trigger), .irq(irq),
        .current_source_enable(cse), .ref_pin_connect(rpc), .converter_high_speed_mode(hsm),
        .conversion_trigger_select(tsel), .negative_input_select0(ns0),
        .negative_input_select1(ns1), .negative_input_select2(ns2),
        .negative_input_select3(ns3));
    analog_side_model model (.vpos(vpos), .cmp_vs_ref(cmp_vs_ref), .cmp_vs_converter(cvc),
        .cmp_vs_shared_pin(cvs), .cmp_vs_channel_pin(cvp));
    initial begin
        forever #4 aclk = ~aclk;
    end
    // counts one-cycle trigger pulses of channel 0
    always @(posedge aclk) begin
        if (convt[0] === 1'b1) n_trig <= n_trig + 1;
    end
    // hang guard, generous against some 800 cycles of tests
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            errors = errors + 1;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    // address and data go out together, each dropped at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        wr_resp = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 0;
    endtask
    task automatic settle();
        repeat (24) @(posedge aclk);
    endtask
    initial begin
        // rows: channel, negative select, positive voltage, expected output
        rows = '{{2'd0, 3'd0, 4'd3, 1'b1}, {2'd0, 3'd1, 4'd4, 1'b0}, {2'd1, 3'd3, 4'd9, 1'b1},
            {2'd1, 3'd2, 4'd6, 1'b0}, {2'd2, 3'd5, 4'd6, 1'b1}, {2'd2, 3'd5, 4'd5, 1'b0},
            {2'd3, 3'd6, 4'd8, 1'b1}, {2'd3, 3'd7, 4'd8, 1'b0}, {2'd0, 3'd7, 4'd10, 1'b1},
            {2'd1, 3'd4, 4'd15, 1'b0}};
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rd(`OFS_CONV_CTRL);
        chk_word(rd_data, 32'h0);
        rd(`OFS_CMP_CLK_DIV);
        chk_word(rd_data, 32'h7);
        wr(`OFS_CMP_CLK_DIV, 32'h1);
        wr(`OFS_MASK, 32'h1);
        for (int i = 0; i < 10; i++) begin
            vpos[4*rows[i][9:8]+:4] <= rows[i][4:1];
            wr(`OFS_CH_CTRL0 + 8'(4 * rows[i][9:8]), {24'h0, 5'h10, rows[i][7:5]});
            settle();
            chk_bit(outs[rows[i][9:8]], rows[i][0]);
            chk_bit(chirq[rows[i][9:8]], 1'b0);
        end
        chk_word({20'h0, ns3, ns2, ns1, ns0}, 32'hF67);
        $display("test select table done");
        // sense codes toggle, reserved, fall, rise on channel 0 against the shared pin
        for (int c = 0; c < 4; c++) begin
            vpos[3:0] <= 4'h0;
            wr(`OFS_CH_CTRL0, {24'h0, 4'hC | 4'(c), 4'h6});
            settle();
            rd(`OFS_STATUS);
            trig_base = n_trig;
            vpos[3:0] <= 4'hF;
            settle();
            chk_bit(chirq[0], c == 3 || c == 0);
            chk_bit(irq, c == 3 || c == 0);
            chk_word(n_trig - trig_base, (c == 3 || c == 0) ? 32'h1 : 32'h0);
            rd(`OFS_STATUS);
            chk_bit(rd_data[0], c == 3 || c == 0);
            rd(`OFS_STATUS);
            chk_bit(rd_data[0], 1'b0);
            vpos[3:0] <= 4'h0;
            settle();
            rd(`OFS_STATUS);
            chk_bit(rd_data[0], c == 2 || c == 0);
        end
        $display("test sense codes done");
        wr(`OFS_CH_CTRL0, 32'h76);
        vpos[3:0] <= 4'hF;
        settle();
        chk_bit(outs[0], 1'b0);
        rd(`OFS_STATUS);
        chk_bit(rd_data[0], 1'b0);
        vpos[3:0] <= 4'h0;
        vpos[7:4] <= 4'hF;
        wr(`OFS_CH_CTRL1, 32'h8E);
        settle();
        chk_bit(capture_trigger, 1'b1);
        wr(`OFS_CH_CTRL1, 32'h86);
        settle();
        chk_bit(capture_trigger, 1'b0);
        $display("test disable and capture done");
        wr(8'h40, 32'h0);
        chk_word({30'h0, wr_resp}, 32'h2);
        rd(8'h40);
        chk_word({30'h0, rd_resp}, 32'h2);
        chk_word(rd_data, 32'h0);
        wr(`OFS_CONV_CTRL, 32'hFF);
        rd(`OFS_CONV_CTRL);
        chk_word(rd_data, 32'hEF);
        chk_word({24'h0, hsm, cse, rpc, 1'b0, tsel}, 32'hEF);
        wr(`OFS_CONV_CTRL, 32'h5A);
        rd(`OFS_CONV_CTRL);
        chk_word(rd_data, 32'h4A);
        chk_word({24'h0, hsm, cse, rpc, 1'b0, tsel}, 32'h4A);
        @(posedge aclk);
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        #1;
        chk_word({24'h0, hsm, cse, rpc, 1'b0, tsel}, 32'h0);
        rd(`OFS_CONV_CTRL);
        chk_word(rd_data, 32'h0);
        $display("test control register done");
        end_of_test();
    end
endmodule
bind comparator_event_control comparator_event_control_monitor mon (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .comparator_output(comparator_output), .conversion_trigger(conversion_trigger),
    .capture_trigger(capture_trigger), .current_source_enable(current_source_enable));
